/* logic/rxc_ctrl.sv */
// top: reset/exception control and status registers on AXI4-Lite
`timescale 1ns/100ps
module rxc_ctrl
	import rxc_pkg::*;
(
	// clock, resets
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        por_n,
	input  wire logic        test_reset,
	// fault detectors
	input  wire rxc_fault_t  fault,
	// axi4-lite write address, data and response
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// reset and abort requests, override bits
	output logic             sys_reset_req,
	output logic             abort_req,
	output logic [2:0]       override_bits
);

	typedef struct packed {
		logic        aw_held;
		logic [11:0] aw_addr;
		logic        aw_priv;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [2:0]  ovr;
		logic        sw_pending;
		logic        reset_req;
		logic        abort;
	} rxc_state_t;

	rxc_state_t st;
	rxc_state_t next_st;
	rxc_flags_t flags;
	rxc_flags_t set_flags;
	rxc_flags_t clr_data;
	logic       clr_we;
	logic       do_write;
	logic       ovr_on;
	logic       per_hit;
	logic       mem_hit;
	logic       adr_hit;
	logic       map_hit;

	function automatic logic [31:0] read_reg(input logic [11:0] a,
		input logic [2:0] ovr, input rxc_flags_t f);
		logic [31:0] v;
		v = 32'h0;
		if (a == RXC_CTRL_OFS) begin
			v[RXC_KEY_HI:RXC_KEY_LO] = RXC_KEY_IDLE;
			v[2:0] = ovr;
		end else if (a == RXC_STAT_OFS) begin
			v[RXC_FLAG_HI:RXC_FLAG_LO] = f;
		end
		return v;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return (a == RXC_CTRL_OFS) || (a == RXC_STAT_OFS);
	endfunction

	////////////////////////////////////////////////////////////////////
	// fault qualification

	always_comb begin
		ovr_on  = test_reset;
		per_hit = fault.periph_violation
			&& !(ovr_on && st.ovr[RXC_OVR_PER]);
		mem_hit = fault.memory_rights
			&& !(ovr_on && st.ovr[RXC_OVR_MEM]);
		adr_hit = fault.illegal_address
			&& !(ovr_on && st.ovr[RXC_OVR_ADR]);
		map_hit = fault.map_overlap && fault.overlap_access;
		set_flags = '0;
		set_flags.power_up        = !por_n;
		set_flags.clock_fault     = fault.clock_fault;
		set_flags.watchdog        = fault.watchdog;
		set_flags.illegal_mode    = fault.illegal_mode;
		set_flags.illegal_address = adr_hit && !fault.user_mode;
		set_flags.illegal_memory_access =
			mem_hit && !fault.user_mode;
		set_flags.periph_illegal_access =
			per_hit && fault.user_mode;
		set_flags.illegal_map     = fault.map_overlap;
		set_flags.software_reset  = st.sw_pending;
	end

	////////////////////////////////////////////////////////////////////
	// bus and control next state

	always_comb begin
		next_st  = st;
		do_write = st.aw_held && st.w_held && !st.bvalid;
		clr_we   = 1'b0;
		clr_data = '1;
		if (s_axi_awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
			next_st.aw_priv = s_axi_awprot[0];
		end
		if (s_axi_wvalid && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		next_st.sw_pending = 1'b0;
		if (do_write) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = mapped(st.aw_addr) ? RXC_RESP_OKAY
				: RXC_RESP_SLV;
			if (st.aw_addr == RXC_CTRL_OFS && st.aw_priv) begin
				if (st.w_strb[0])
					next_st.ovr = st.w_data[2:0];
				if (st.w_strb[1] && st.w_data[RXC_KEY_HI:RXC_KEY_LO]
					!= RXC_KEY_IDLE)
					next_st.sw_pending = 1'b1;
			end
			if (st.aw_addr == RXC_STAT_OFS) begin
				clr_we = 1'b1;
				clr_data = st.w_data[RXC_FLAG_HI:RXC_FLAG_LO];
				if (!st.w_strb[0])
					clr_data.software_reset = 1'b1;
				if (!st.w_strb[1])
					clr_data[8:1] = '1;
			end
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;
		if (st.rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = read_reg(s_axi_araddr, st.ovr, flags);
			next_st.rresp  = mapped(s_axi_araddr) ? RXC_RESP_OKAY
				: RXC_RESP_SLV;
		end
		next_st.reset_req = st.sw_pending || fault.watchdog
			|| fault.clock_fault || fault.illegal_mode
			|| map_hit || ((adr_hit || mem_hit) && !fault.user_mode);
		next_st.abort = (per_hit || adr_hit || mem_hit)
			&& fault.user_mode;
	end

	// bus and control state follow the system reset; cause flags do not
	always_ff @(posedge clk) begin
		if (!rst_n || !por_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	rxc_cause_store u_store (
		.clk       (clk),
		.por_n     (por_n),
		.set_flags (set_flags),
		.clr_we    (clr_we),
		.clr_data  (clr_data),
		.flags     (flags)
	);

	always_comb begin
		s_axi_awready = !st.aw_held;
		s_axi_wready  = !st.w_held;
		s_axi_bvalid  = st.bvalid;
		s_axi_bresp   = st.bresp;
		s_axi_arready = !st.rvalid;
		s_axi_rvalid  = st.rvalid;
		s_axi_rdata   = st.rdata;
		s_axi_rresp   = st.rresp;
		sys_reset_req = st.reset_req;
		abort_req     = st.abort;
		override_bits = st.ovr;
	end

	////////////////////////////////////////////////////////////////////
	// assertions

	property p_key_reads_idle;
		@(posedge clk) disable iff (!rst_n)
		(s_axi_arvalid && !st.rvalid && s_axi_araddr == RXC_CTRL_OFS)
		|=> (s_axi_rdata[15:14] == 2'h1);
	endproperty
	a_key_reads_idle: assert property (p_key_reads_idle)
		else $error("key field not read as 01");

	property p_sw_reset;
		@(posedge clk) disable iff (!rst_n || !por_n)
		st.sw_pending |=> sys_reset_req;
	endproperty
	a_sw_reset: assert property (p_sw_reset)
		else $error("software key did not request reset");

	property p_user_no_write;
		@(posedge clk) disable iff (!rst_n)
		(do_write && !st.aw_priv) |=> $stable(st.ovr);
	endproperty
	a_user_no_write: assert property (p_user_no_write)
		else $error("user write changed control");

	property p_ovr_off;
		@(posedge clk) disable iff (!rst_n)
		(!test_reset && fault.periph_violation && fault.user_mode)
		|=> abort_req;
	endproperty
	a_ovr_off: assert property (p_ovr_off)
		else $error("override acted outside test mode");

	property p_per_ovr;
		@(posedge clk) disable iff (!rst_n)
		(test_reset && st.ovr[2] && !fault.memory_rights
		 && !fault.illegal_address) |=> !abort_req;
	endproperty
	a_per_ovr: assert property (p_per_ovr)
		else $error("overridden violation aborted");

	property p_mem_ovr;
		@(posedge clk) disable iff (!rst_n)
		(test_reset && st.ovr[1] && fault.memory_rights
		 && !fault.user_mode) |-> !set_flags.illegal_memory_access;
	endproperty
	a_mem_ovr: assert property (p_mem_ovr)
		else $error("overridden rights violation flagged");

	property p_adr_ovr;
		@(posedge clk) disable iff (!rst_n)
		(!st.ovr[0] && fault.illegal_address && !fault.user_mode)
		|=> sys_reset_req;
	endproperty
	a_adr_ovr: assert property (p_adr_ovr)
		else $error("illegal address did not reset");

	property p_por_flag;
		@(posedge clk) !por_n |=> flags.power_up;
	endproperty
	a_por_flag: assert property (p_por_flag)
		else $error("power-up flag not set");

	property p_survive;
		@(posedge clk) disable iff (!por_n)
		(!rst_n && flags.watchdog && !clr_we) |=> flags.watchdog;
	endproperty
	a_survive: assert property (p_survive)
		else $error("flag lost in system reset");

	property p_clr_flag;
		@(posedge clk) disable iff (!por_n)
		(clr_we && !clr_data.power_up && !set_flags.power_up)
		|=> !flags.power_up;
	endproperty
	a_clr_flag: assert property (p_clr_flag)
		else $error("zero write did not clear flag");

	property p_clk_fault;
		@(posedge clk) disable iff (!rst_n || !por_n)
		fault.clock_fault |=> (sys_reset_req && flags.clock_fault);
	endproperty
	a_clk_fault: assert property (p_clk_fault)
		else $error("clock fault not recorded");

	property p_wd_flag;
		@(posedge clk) disable iff (!rst_n || !por_n)
		fault.watchdog |=> (sys_reset_req && flags.watchdog);
	endproperty
	a_wd_flag: assert property (p_wd_flag)
		else $error("watchdog reset not recorded");

	property p_mode_flag;
		@(posedge clk) disable iff (!rst_n || !por_n)
		fault.illegal_mode |=> (sys_reset_req && flags.illegal_mode);
	endproperty
	a_mode_flag: assert property (p_mode_flag)
		else $error("illegal mode not recorded");

	property p_adr_flag;
		@(posedge clk) disable iff (!por_n)
		(fault.illegal_address && !fault.user_mode && !test_reset)
		|=> flags.illegal_address;
	endproperty
	a_adr_flag: assert property (p_adr_flag)
		else $error("illegal address not recorded");

	property p_acc_flag;
		@(posedge clk) disable iff (!por_n)
		(fault.memory_rights && !fault.user_mode && !test_reset)
		|=> flags.illegal_memory_access;
	endproperty
	a_acc_flag: assert property (p_acc_flag)
		else $error("rights violation not recorded");

	property p_per_flag;
		@(posedge clk) disable iff (!por_n)
		(fault.periph_violation && fault.user_mode && !test_reset)
		|=> flags.periph_illegal_access;
	endproperty
	a_per_flag: assert property (p_per_flag)
		else $error("peripheral violation not recorded");

	property p_map;
		@(posedge clk) disable iff (!rst_n || !por_n)
		(fault.map_overlap && fault.overlap_access)
		|=> (sys_reset_req && flags.illegal_map);
	endproperty
	a_map: assert property (p_map)
		else $error("overlap access did not reset");

	property p_sw_flag;
		@(posedge clk) disable iff (!por_n)
		st.sw_pending |=> flags.software_reset;
	endproperty
	a_sw_flag: assert property (p_sw_flag)
		else $error("software reset not recorded");

	c_write: cover property (@(posedge clk) do_write);
	c_read: cover property (@(posedge clk) st.rvalid && s_axi_rready);
	c_sw: cover property (@(posedge clk) st.sw_pending);
	c_abort: cover property (@(posedge clk) abort_req);

endmodule

/* logic/rxc_pkg.sv */
// package: register map, field positions and types for reset/exception control
// Summary of operation
// - reset key field reads 01; writing 01 is idle, anything else resets
// - control register writes need privileged mode; reads allowed always
// - override bits act only while test reset input is high
// - periph override set: peripheral violation causes no reset or abort
// - memory rights override set: rights violation ignored
// - illegal address override set: illegal address takes no action
// - only the power-up flag set after power-up; set flags survive the resulting reset
// - new reset conditions other than power-on never clear recorded flags
// - writing 0 clears a flag, writing 1 leaves it
// - power-up flag set whenever power-on reset input is active
// - clock fault flag set on clock fault, cleared at power-up or by a zero write
// - watchdog flag set when watchdog caused the reset
// - illegal mode flag set on illegal processor mode value
// - illegal address flag set on unimplemented access in non-user mode
// - illegal memory access flag set on non-user permission violation
// - peripheral illegal access flag set on user-mode violation
// - overlapping memory map sets map flag; access to overlap resets
// - software reset flag set when key write caused the reset
// - reserved bits ignore writes and read as zero
package rxc_pkg;

	localparam logic [11:0] RXC_CTRL_OFS   = 12'h000;
	localparam logic [11:0] RXC_STAT_OFS   = 12'h004;
	localparam int          RXC_KEY_HI     = 15;
	localparam int          RXC_KEY_LO     = 14;
	localparam logic [1:0]  RXC_KEY_IDLE   = 2'h1;
	localparam int          RXC_OVR_PER    = 2;
	localparam int          RXC_OVR_MEM    = 1;
	localparam int          RXC_OVR_ADR    = 0;
	localparam int          RXC_FLAG_LO    = 7;
	localparam int          RXC_FLAG_HI    = 15;
	localparam logic [1:0]  RXC_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RXC_RESP_SLV   = 2'h2;

	// flag order within the 9-bit field, bit 0 = position 7
	typedef struct packed {
		logic power_up;
		logic clock_fault;
		logic watchdog;
		logic illegal_mode;
		logic illegal_address;
		logic illegal_memory_access;
		logic periph_illegal_access;
		logic illegal_map;
		logic software_reset;
	} rxc_flags_t;

	// power-on value of the cause flags: only the power-up flag is set
	localparam rxc_flags_t  RXC_FLAGS_POR  = 9'h100;

	// fault detector inputs, one pulse or level per cycle
	typedef struct packed {
		logic clock_fault;
		logic watchdog;
		logic illegal_mode;
		logic illegal_address;
		logic memory_rights;
		logic periph_violation;
		logic map_overlap;
		logic overlap_access;
		logic user_mode;
	} rxc_fault_t;

endpackage

/* logic/rxc_cause_store.sv */
// sticky reset cause flags, cleared only by power-on or software zero write
`timescale 1ns/100ps
module rxc_cause_store
	import rxc_pkg::*;
(
	// clock and power-on reset
	input  wire logic       clk,
	input  wire logic       por_n,
	// set and clear strobes
	input  wire rxc_flags_t set_flags,
	input  wire logic       clr_we,
	input  wire rxc_flags_t clr_data,
	// flags
	output rxc_flags_t      flags
);

	typedef struct packed {
		rxc_flags_t f;
	} rxc_store_t;

	rxc_store_t st;
	rxc_store_t next_st;

	// set wins over a simultaneous clear so no cause is lost
	always_comb begin
		next_st = st;
		if (clr_we)
			next_st.f = st.f & clr_data;
		next_st.f = next_st.f | set_flags;
	end

	// only the power-on reset reaches this storage
	always_ff @(posedge clk) begin
		if (!por_n)
			st <= '{f: RXC_FLAGS_POR};
		else
			st <= next_st;
	end

	assign flags = st.f;

	property p_set_sticks;
		@(posedge clk) disable iff (!por_n)
		(set_flags != '0)
		|=> ((flags & $past(set_flags)) == $past(set_flags));
	endproperty
	a_set_sticks: assert property (p_set_sticks)
		else $error("set flag not recorded");

endmodule

/* test/rxc_fault_src.sv */
// fault detector model: raises one fault pattern for one clock cycle
`timescale 1ns/100ps
module rxc_fault_src
	import rxc_pkg::*;
(
	// clock
	input  wire logic clk,
	// detector outputs
	output rxc_fault_t fault
);
	initial fault = '0;
	// detectors report a level for one cycle, then go quiet again
	task automatic hit(input rxc_fault_t f);
		@(posedge clk);
		fault <= f;
		@(posedge clk);
		fault <= '0;
	endtask
endmodule

/* test/test_rxc_ctrl.sv */
// self-checking bench for the reset/exception control block
`timescale 1ns/100ps
module test_rxc_ctrl;
	import rxc_pkg::*;
	logic clk = 0, rst_n = 0, por_n = 0, test_reset = 0;
	rxc_fault_t fault;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [2:0] awprot = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, sys_reset_req, abort_req;
	logic [31:0] wdata = '0, rdata, rd_v;
	logic [1:0] bresp, rresp, rd_r;
	logic [2:0] override_bits;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] wr_r;
	logic pr = 0, pa = 0;
	int error_cnt = 0, n_tests = 0, ev_r = 0, ev_a = 0;
	always #10 clk = ~clk;
	rxc_fault_src rxc_fault_src_i (.clk(clk), .fault(fault));
	rxc_ctrl rxc_ctrl_i (.clk(clk), .rst_n(rst_n), .por_n(por_n),
		.test_reset(test_reset), .fault(fault), .s_axi_awaddr(awaddr),
		.s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h1), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sys_reset_req(sys_reset_req), .abort_req(abort_req),
		.override_bits(override_bits));
	// count rising edges of reset and abort requests apart
	always @(posedge clk) begin
		if (sys_reset_req && !pr)
			ev_r++;
		if (abort_req && !pa)
			ev_a++;
		pr <= sys_reset_req;
		pa <= abort_req;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			error_cnt++;
			$display("Error at %0t: got %h exp %h", $time, g, x);
		end
	endtask
	// slave outputs read just after the edge still hold the sampled value
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic p);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awprot <= {2'h0, p};
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 0;
			if (wvalid && wready)
				wvalid <= 0;
			if (bvalid) begin
				done = 1'b1;
				wr_r = bresp;
				bready <= 0;
			end
		end
	endtask
	task automatic rd(input logic [11:0] a);
		logic done;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 0;
			if (rvalid) begin
				done = 1'b1;
				rd_v = rdata;
				rd_r = rresp;
				rready <= 0;
			end
		end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] x);
		rd(a);
		chk(rd_v, x);
	endtask
	task automatic fire(input rxc_fault_t f, input logic xr, input logic xa);
		int er;
		int ea;
		er = ev_r;
		ea = ev_a;
		rxc_fault_src_i.hit(f);
		repeat (3) @(posedge clk);
		chk(ev_r - er, {31'h0, xr});
		chk(ev_a - ea, {31'h0, xa});
	endtask
	task automatic pulse_rst(input logic por);
		@(posedge clk);
		rst_n <= 0;
		por_n <= ~por;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		por_n <= 1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
	task automatic test_regs;
		rchk(RXC_STAT_OFS, 32'h0000_8000);
		rchk(RXC_CTRL_OFS, 32'h0000_4000);
		rd(12'h008);
		chk({30'h0, rd_r}, {30'h0, RXC_RESP_SLV});
		wr(12'h00c, 32'h0, 1);
		chk({30'h0, wr_r}, {30'h0, RXC_RESP_SLV});
		wr(RXC_STAT_OFS, 32'hffff_ffff, 0);
		chk({30'h0, wr_r}, {30'h0, RXC_RESP_OKAY});
		rchk(RXC_STAT_OFS, 32'h0000_8000);
		wr(RXC_STAT_OFS, 32'h0, 0);
		rchk(RXC_STAT_OFS, 32'h0);
		wr(RXC_CTRL_OFS, 32'hffff_7fff, 0);
		chk({30'h0, wr_r}, {30'h0, RXC_RESP_OKAY});
		rchk(RXC_CTRL_OFS, 32'h0000_4000);
		chk({29'h0, override_bits}, 32'h0);
	endtask
	task automatic test_override;
		test_reset <= 1;
		wr(RXC_CTRL_OFS, 32'hffff_7fff, 1);
		rchk(RXC_CTRL_OFS, 32'h0000_4007);
		chk({29'h0, override_bits}, 32'h7);
		fire(9'h009, 0, 0);
		fire(9'h010, 0, 0);
		fire(9'h020, 0, 0);
		rchk(RXC_STAT_OFS, 32'h0);
		wr(RXC_CTRL_OFS, 32'h0000_4000, 1);
		fire(9'h020, 1, 0);
		rchk(RXC_STAT_OFS, 32'h0000_0800);
		wr(RXC_STAT_OFS, 32'h0, 1);
		wr(RXC_CTRL_OFS, 32'h0000_4007, 1);
	endtask
	task automatic test_normal;
		test_reset <= 0;
		fire(9'h009, 0, 1);
		fire(9'h010, 1, 0);
		fire(9'h020, 1, 0);
		rchk(RXC_STAT_OFS, 32'h0000_0e00);
		wr(RXC_STAT_OFS, 32'h0, 1);
		rchk(RXC_STAT_OFS, 32'h0);
	endtask
	task automatic test_sw_reset;
		int er;
		for (int k = 0; k < 4; k++) begin
			er = ev_r;
			wr(RXC_CTRL_OFS, {16'h0, k[1:0], 14'h0007}, 1);
			repeat (3) @(posedge clk);
			chk(ev_r - er, {31'h0, k != 1});
		end
		pulse_rst(0);
		rchk(RXC_STAT_OFS, 32'h0000_0080);
		rchk(RXC_CTRL_OFS, 32'h0000_4000);
	endtask
	task automatic test_sticky;
		rxc_fault_src_i.hit(9'h080);
		rxc_fault_src_i.hit(9'h100);
		rxc_fault_src_i.hit(9'h040);
		rchk(RXC_STAT_OFS, 32'h0000_7080);
		fire(9'h004, 0, 0);
		fire(9'h006, 1, 0);
		pulse_rst(0);
		rchk(RXC_STAT_OFS, 32'h0000_7180);
		wstrb <= 4'h2;
		wr(RXC_STAT_OFS, 32'h0, 0);
		wstrb <= 4'hf;
		rchk(RXC_STAT_OFS, 32'h0000_0080);
		pulse_rst(1);
		rchk(RXC_STAT_OFS, 32'h0000_8000);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		por_n <= 1;
		test_regs();
		test_override();
		test_normal();
		test_sw_reset();
		test_sticky();
		stop_test();
	end
endmodule
